/* File: rtl/sws_defs.vh */
// constants for the service window supervisor: offsets, fields, reset values and timing
`ifndef SWS_DEFS_VH
`define SWS_DEFS_VH

// register offsets on the plain register port
`define SWS_OFS_SERVICE 4'h0
`define SWS_OFS_STATUS 4'h1
`define SWS_OFS_CONTROL 4'h2

// service_key_window field positions
`define SWS_SEL_HI 7
`define SWS_SEL_LO 6
`define SWS_KEY_HI 5
`define SWS_KEY_LO 1
`define SWS_CMEN_BIT 0

// status field positions
`define SWS_ST_PEND_BIT 0
`define SWS_ST_FAULT_BIT 1
`define SWS_ST_CMERR_BIT 2
`define SWS_ST_CONF_BIT 3
`define SWS_ST_RUN_BIT 4

// control field positions
`define SWS_CTL_CLOCK_DELAY_BIT_BIT 0

// fixed key and reset values
`define SWS_KEY 5'h0C
`define SWS_KEY_READ 5'h00
`define SWS_SEL_RST 2'h3
`define SWS_CMEN_RST 1'b1
`define SWS_CLOCK_DELAY_BIT_RST 1'b0

// window limits in instruction cycles
`define SWS_LOWER_CYC 17'h00800
`define SWS_UPPER_8K 17'h02000
`define SWS_UPPER_16K 17'h04000
`define SWS_UPPER_32K 17'h08000
`define SWS_UPPER_64K 17'h10000

// fault pin hold after the pin is seen low or the clock recovers, instruction cycles
`define SWS_HOLD_CYC 5'h10

// idle timer width and the bit whose toggle sets the pending flag
`define SWS_IDLE_W 13
`define SWS_IDLE_BIT 12

// clock monitor: longest allowed gap between instruction cycles
`define SWS_CLK_MHZ 125
`define SWS_CM_LIMIT_US 1000

`endif

/* File: rtl/sws_supervisor.v */
// service window supervisor with clock monitor, idle timer and open-drain fault pin
`timescale 1ns/1ns
`include "sws_defs.vh"
`default_nettype none

// operation overview
// all window, hold and idle counts advance on instr_cycle pulses only,
// so the block follows the core's instruction rate, not the system clock.
//
// configuration
// after reset the window select is at its largest code and the monitor is on.
// the first keyed write to the service register loads select and monitor enable.
// from then on both fields are frozen until the next reset.
// a first write with a wrong key is an error, like any later bad write.
//
// service window
// the window counter restarts on every accepted service.
// a later service must match select, key and monitor enable exactly.
// a later service before the lower limit counts as an error.
// the first service after reset has no lower limit at all.
// reaching the selected upper limit without a service is an error.
// the counter holds its value while an error is being signalled.
//
// fault pin
// the pin is open drain: the block only ever drives it low.
// fault_pin_oe high means the pin is pulled low by this block.
// the hold count starts only once the sensed pin level is low,
// so a heavily loaded pin still gets the full low time.
// after the hold the pin is released and the block waits for it to rise.
// a pin that never rises keeps the window stopped; a pull-up is needed.
// service writes are ignored from the error until the pin is seen high.
//
// clock monitor
// it counts system clocks since the last instruction cycle pulse.
// a gap longer than the limit raises the clock error.
// the error clears on the next pulse, then the normal hold follows.
// the monitor keeps running in halt and idle, so a stuck halt is reported.
// with the monitor disabled by the first write no clock error is raised.
//
// low power modes
// the window counter is frozen while halt or idle is high.
// leaving idle restarts the window, so the lower limit applies again.
// leaving halt restarts the window unless the rc option is fitted
// and the clock delay bit is clear; then the count simply resumes.
//
// idle timer
// it is a free running counter of instruction cycles, never reset.
// its pending flag is set whenever its top bit toggles.
// software clears the flag by writing one to the status register.
// a set and a clear in the same cycle leave the flag set.
//
// register port
// reads return data in the cycle after the read strobe and zero otherwise.
// the key field of the service register always reads as zero.
// unmapped addresses read as zero and ignore writes.

module sws_supervisor #(
  parameter ADDR_W = 4,
  parameter [16:0] CM_LIMIT_CYC = `SWS_CM_LIMIT_US * `SWS_CLK_MHZ
) (
  input wire clk, // system clock, 125 MHz
  input wire sys_rst, // synchronous reset, active high
  input wire instr_cycle, // one-clock pulse per instruction cycle
  input wire halt_mode, // core is in halt mode
  input wire idle_mode, // core is in idle mode
  input wire rc_osc_opt, // single-pin rc oscillator option fitted
  input wire [ADDR_W-1:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output wire [7:0] reg_rdata, // read data, valid the cycle after reg_rd
  input wire fault_pin_i, // sensed level of the fault pin
  output wire fault_pin_o, // driven level of the fault pin, always low
  output wire fault_pin_oe, // high while the fault pin is pulled low
  output wire idle_timer_pending // idle timer pending flag
);

  // fault pin states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DRIVE = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;
  localparam [1:0] ST_REL = 2'h3;

  // upper window limit for a select code
  function [16:0] upper_lim;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: upper_lim = `SWS_UPPER_8K;
        2'h1: upper_lim = `SWS_UPPER_16K;
        2'h2: upper_lim = `SWS_UPPER_32K;
        default: upper_lim = `SWS_UPPER_64K;
      endcase
    end
  endfunction

  // register address decode, used by both the write and read paths
  function hit;
    input [ADDR_W-1:0] addr;
    input [3:0] ofs;
    begin
      hit = (addr == ofs[ADDR_W-1:0]);
    end
  endfunction

  reg [1:0] sel_ff;
  reg cmen_ff;
  reg conf_ff;
  reg clock_delay_bit_ff;
  reg [16:0] wd_cnt_ff;
  reg [16:0] nxt_wd_cnt;
  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [4:0] hold_ff;
  reg [4:0] nxt_hold;
  reg oe_ff;
  reg nxt_oe;
  reg out_lvl_ff;
  reg [16:0] gap_ff;
  reg cm_err_ff;
  reg halt_d_ff;
  reg idle_d_ff;
  reg [`SWS_IDLE_W-1:0] idle_cnt_ff = {`SWS_IDLE_W{1'b0}};
  reg pend_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg win_restart;

  wire [16:0] upper;
  wire win_run;
  wire svc_wr;
  wire key_ok;
  wire fields_ok;
  wire early;
  wire svc_ok;
  wire svc_bad;
  wire timeout;
  wire sup_err;
  wire halt_exit;
  wire idle_exit;
  wire halt_reload;
  wire pend_set;
  wire pend_clr;

  assign upper = upper_lim(sel_ff);
  // the window only runs when no fault is under way and the core is awake
  assign win_run = (st_ff == ST_IDLE) && !halt_mode && !idle_mode;
  // a service is only looked at while the window runs: no fault under way, core awake
  assign svc_wr = reg_wr && hit(reg_addr, `SWS_OFS_SERVICE) && win_run;
  assign key_ok = (reg_wdata[`SWS_KEY_HI:`SWS_KEY_LO] == `SWS_KEY);
  assign fields_ok = key_ok && (reg_wdata[`SWS_SEL_HI:`SWS_SEL_LO] == sel_ff)
                     && (reg_wdata[`SWS_CMEN_BIT] == cmen_ff);
  // no lower limit before the first service after reset
  assign early = conf_ff && (wd_cnt_ff < `SWS_LOWER_CYC);
  assign svc_ok = svc_wr && (conf_ff ? (fields_ok && !early) : key_ok);
  assign svc_bad = svc_wr && !svc_ok;
  assign timeout = win_run && instr_cycle && ((wd_cnt_ff + 17'h00001) == upper);
  assign sup_err = svc_bad || timeout;
  assign halt_exit = halt_d_ff && !halt_mode;
  assign idle_exit = idle_d_ff && !idle_mode;
  // rc option with the delay bit clear keeps the count across halt
  assign halt_reload = halt_exit && !(rc_osc_opt && !clock_delay_bit_ff);
  assign pend_set = instr_cycle && (idle_cnt_ff[`SWS_IDLE_BIT-1:0] == {`SWS_IDLE_BIT{1'b1}});
  assign pend_clr = reg_wr && hit(reg_addr, `SWS_OFS_STATUS) && reg_wdata[`SWS_ST_PEND_BIT];

  // configuration: loaded once by the first keyed write, then frozen
  always @(posedge clk) begin
    if (sys_rst) begin
      sel_ff <= `SWS_SEL_RST;
      cmen_ff <= `SWS_CMEN_RST;
      conf_ff <= 1'b0;
    end else if (svc_ok && !conf_ff) begin
      sel_ff <= reg_wdata[`SWS_SEL_HI:`SWS_SEL_LO];
      cmen_ff <= reg_wdata[`SWS_CMEN_BIT];
      conf_ff <= 1'b1;
    end
  end

  // clock delay control bit
  always @(posedge clk) begin
    if (sys_rst) begin
      clock_delay_bit_ff <= `SWS_CLOCK_DELAY_BIT_RST;
    end else if (reg_wr && hit(reg_addr, `SWS_OFS_CONTROL)) begin
      clock_delay_bit_ff <= reg_wdata[`SWS_CTL_CLOCK_DELAY_BIT_BIT];
    end
  end

  // window counter: restarted by services, pin release, idle exit and halt reload
  always @* begin
    nxt_wd_cnt = wd_cnt_ff;
    if (win_restart || svc_ok || idle_exit || halt_reload) begin
      nxt_wd_cnt = 17'h00000;
    end else if (win_run && instr_cycle && !timeout) begin
      nxt_wd_cnt = wd_cnt_ff + 17'h00001;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wd_cnt_ff <= 17'h00000;
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
    end
  end

  // halt and idle edge detection
  always @(posedge clk) begin
    if (sys_rst) begin
      halt_d_ff <= 1'b0;
      idle_d_ff <= 1'b0;
    end else begin
      halt_d_ff <= halt_mode;
      idle_d_ff <= idle_mode;
    end
  end

  // clock monitor: counts system clocks since the last instruction cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      gap_ff <= 17'h00000;
      cm_err_ff <= 1'b0;
    end else begin
      if (instr_cycle) begin
        gap_ff <= 17'h00000;
      end else if (gap_ff != CM_LIMIT_CYC) begin
        gap_ff <= gap_ff + 17'h00001;
      end
      // still runs in halt and idle, so a stopped clock is reported
      cm_err_ff <= cmen_ff && !instr_cycle && (gap_ff == CM_LIMIT_CYC);
    end
  end

  // fault pin sequencer shared by both error sources
  always @* begin
    nxt_st = st_ff;
    nxt_hold = hold_ff;
    nxt_oe = oe_ff;
    win_restart = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        if (sup_err || cm_err_ff) begin
          nxt_st = ST_DRIVE;
          nxt_oe = 1'b1;
        end
      end
      ST_DRIVE: begin
        nxt_hold = 5'h00;
        if (!fault_pin_i && !cm_err_ff) begin
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cm_err_ff) begin
          nxt_st = ST_DRIVE;
        end else if (instr_cycle) begin
          nxt_hold = hold_ff + 5'h01;
          if (hold_ff == `SWS_HOLD_CYC - 5'h01) begin
            nxt_st = ST_REL;
            nxt_oe = 1'b0;
          end
        end
      end
      ST_REL: begin
        if (cm_err_ff) begin
          nxt_st = ST_DRIVE;
          nxt_oe = 1'b1;
        end else if (fault_pin_i) begin
          nxt_st = ST_IDLE;
          win_restart = 1'b1;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      hold_ff <= 5'h00;
      oe_ff <= 1'b0;
      out_lvl_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      hold_ff <= nxt_hold;
      oe_ff <= nxt_oe;
      out_lvl_ff <= 1'b0;
    end
  end

  // idle timer: free running, never cleared by reset
  always @(posedge clk) begin
    if (instr_cycle) begin
      idle_cnt_ff <= idle_cnt_ff + {{(`SWS_IDLE_W-1){1'b0}}, 1'b1};
    end
  end

  // pending flag: set wins over a software clear
  always @(posedge clk) begin
    if (sys_rst) begin
      pend_ff <= 1'b0;
    end else if (pend_set) begin
      pend_ff <= 1'b1;
    end else if (pend_clr) begin
      pend_ff <= 1'b0;
    end
  end

  // read mux, data returned one cycle after the strobe
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, `SWS_OFS_SERVICE)) begin
        nxt_rdata[`SWS_SEL_HI:`SWS_SEL_LO] = sel_ff;
        nxt_rdata[`SWS_KEY_HI:`SWS_KEY_LO] = `SWS_KEY_READ;
        nxt_rdata[`SWS_CMEN_BIT] = cmen_ff;
      end else if (hit(reg_addr, `SWS_OFS_STATUS)) begin
        nxt_rdata[`SWS_ST_PEND_BIT] = pend_ff;
        nxt_rdata[`SWS_ST_FAULT_BIT] = oe_ff;
        nxt_rdata[`SWS_ST_CMERR_BIT] = cm_err_ff;
        nxt_rdata[`SWS_ST_CONF_BIT] = conf_ff;
        nxt_rdata[`SWS_ST_RUN_BIT] = win_run;
      end else if (hit(reg_addr, `SWS_OFS_CONTROL)) begin
        nxt_rdata[`SWS_CTL_CLOCK_DELAY_BIT_BIT] = clock_delay_bit_ff;
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_ff;
  assign fault_pin_o = out_lvl_ff;
  assign fault_pin_oe = oe_ff;
  assign idle_timer_pending = pend_ff;

endmodule // sws_supervisor

`default_nettype wire

/* File: tb/sws_chk.sv */
// concurrent checks on the service window supervisor ports
`timescale 1ns/1ns
`default_nettype none
module sws_chk #(parameter [16:0] CM_LIMIT_CYC = 17'h1E848) (
  input wire clk, // clock
  input wire sys_rst, // reset
  input wire instr_cycle, // cycle strobe
  input wire halt_mode, // halt level
  input wire idle_mode, // idle level
  input wire [3:0] reg_addr, // address
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [7:0] reg_rdata, // read data
  input wire fault_pin_i, // sensed pin
  input wire fault_pin_o, // driven pin level
  input wire fault_pin_oe, // pin enable
  input wire idle_timer_pending // pending flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg [5:0] hold_ff;
  reg [17:0] gap_ff;
  reg cfg_ff;
  // pulses counted while the pin is held low, clocks since the last strobe
  always @(posedge clk) begin
    if (sys_rst || !fault_pin_oe) hold_ff <= 6'h00;
    else if (instr_cycle && !fault_pin_i && hold_ff != 6'h3F) hold_ff <= hold_ff + 6'h01;
    if (sys_rst || instr_cycle) gap_ff <= 18'h00000;
    else if (gap_ff != 18'h3FFFF) gap_ff <= gap_ff + 18'h00001;
    if (sys_rst) cfg_ff <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0) cfg_ff <= 1'b1;
  end
  sequence s_rise;
    $rose(fault_pin_oe);
  endsequence
  sequence s_badkey;
    reg_wr && reg_addr == 4'h0 && reg_wdata[5:1] != 5'h0C && !fault_pin_oe && !halt_mode && !idle_mode;
  endsequence
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !fault_pin_oe && reg_rdata == 8'h00)
    else $error("outputs active after reset");
  AST_PIN_LOW: assert property (fault_pin_oe |-> !fault_pin_o)
    else $error("fault pin driven high");
  AST_KEY_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata[5:1] == 5'h00)
    else $error("key field visible");
  AST_HOLD: assert property ($fell(fault_pin_oe) |-> hold_ff >= 16 && hold_ff <= 33)
    else $error("hold length wrong");
  AST_STAY: assert property (s_rise |-> fault_pin_oe [*8])
    else $error("drive too short");
  AST_CLK_ERR: assert property (gap_ff >= CM_LIMIT_CYC + 3 |-> fault_pin_oe)
    else $error("stalled clock not flagged");
  AST_BAD_KEY: assert property (s_badkey |-> ##[1:3] fault_pin_oe)
    else $error("bad key accepted");
  AST_FIRST_OK: assert property (reg_wr && reg_addr == 4'h0 && !cfg_ff && reg_wdata[5:1] == 5'h0C
    |=> !fault_pin_oe [*3])
    else $error("early first service refused");
  AST_PEND: assert property (idle_timer_pending && !(reg_wr && reg_addr == 4'h1 && reg_wdata[0])
    |=> idle_timer_pending)
    else $error("pending lost");
endmodule // sws_chk
bind sws_supervisor sws_chk #(.CM_LIMIT_CYC(CM_LIMIT_CYC)) chk_i (.clk, .sys_rst, .instr_cycle, .halt_mode,
  .idle_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fault_pin_i, .fault_pin_o, .fault_pin_oe,
  .idle_timer_pending);
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the service window supervisor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg ic = 1'b0;
  reg ic_on = 1'b1;
  reg halt = 1'b0;
  reg idle = 1'b0;
  reg rc = 1'b1;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [7:0] wd = 8'h00;
  wire [7:0] rdat;
  wire pin_o;
  wire oe;
  wire pend;
  wire pin = oe ? pin_o : 1'b1; // pull-up unless driven
  integer fails = 0;
  integer checked = 0;
  integer cyc = 0;
  integer k;
  sws_supervisor #(.CM_LIMIT_CYC(17'h000C8)) uut (.clk(clk), .sys_rst(sys_rst), .instr_cycle(ic),
    .halt_mode(halt), .idle_mode(idle), .rc_osc_opt(rc), .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .fault_pin_i(pin), .fault_pin_o(pin_o), .fault_pin_oe(oe),
    .idle_timer_pending(pend));
  initial forever #4 clk = ~clk;
  // cycle strobe every second clock and hang guard
  always @(posedge clk) begin
    ic <= ic_on & ~ic;
    cyc <= cyc + 1;
    if (cyc > 90000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e, input [39:0] n);
    checked = checked + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("[FAIL] %0s exp %h got %h", n, e, s);
    end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wrr(input [3:0] a, input [7:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdat, e, "rdat");
  endtask
  // bounded wait for the pin enable to reach a level
  task woe(input v, input integer lim);
    k = 0;
    while (oe !== v && k < lim) begin
      @(posedge clk);
      #1 k = k + 1;
    end
  endtask
  task svc(input [7:0] v, input integer n);
    tk(2 * n);
    wrr(4'h0, v);
  endtask
  task rise(input integer lim);
    woe(1'b1, lim);
    chk({7'h00, oe}, 8'h01, "rise");
  endtask
  task hold;
    woe(1'b0, 200);
    chk({7'h00, oe === 1'b0 && k > 29 && k < 67}, 8'h01, "hold");
  endtask
  task t_cfg;
    rdc(4'h0, 8'hC1);
    wrr(4'h0, 8'h19);
    tk(8);
    chk({7'h00, oe}, 8'h00, "cfg");
    rdc(4'h0, 8'h01);
    rdc(4'hF, 8'h00);
  endtask
  task t_window;
    svc(8'h19, 2100);
    tk(8);
    chk({7'h00, oe}, 8'h00, "ok");
    svc(8'h19, 1000);
    rise(8);
    hold;
    svc(8'h19, 1000);
    rise(8);
    hold;
  endtask
  task t_fields;
    svc(8'hD9, 2100);
    rise(8);
    hold;
    svc(8'h1D, 2100);
    rise(8);
    hold;
    svc(8'h18, 2100);
    rise(8);
    hold;
  endtask
  task t_upper;
    tk(16200);
    chk({7'h00, oe}, 8'h00, "early");
    rise(400);
    hold;
  endtask
  task t_clk;
    halt <= 1'b1;
    ic_on <= 1'b0;
    rise(300);
    tk(50);
    rise(1);
    halt <= 1'b0;
    ic_on <= 1'b1;
    hold;
  endtask
  task t_idle;
    tk(4200);
    idle <= 1'b1;
    tk(20);
    idle <= 1'b0;
    svc(8'h19, 1000);
    rise(8);
    hold;
  endtask
  task t_pend;
    chk({7'h00, pend}, 8'h01, "pend");
    wrr(4'h1, 8'h01);
    tk(2);
    chk({7'h00, pend}, 8'h00, "clr");
    rdc(4'h1, 8'h18);
    tk(8200);
    chk({7'h00, pend}, 8'h01, "again");
  endtask
  // rc option with delay clear resumes the count, delay set reloads it
  task t_halt;
    tk(2000);
    halt <= 1'b1;
    tk(20);
    halt <= 1'b0;
    tk(2200);
    wrr(4'h0, 8'h19);
    tk(8);
    chk({7'h00, oe}, 8'h00, "halt");
    wrr(4'h2, 8'h01);
    rdc(4'h2, 8'h01);
    tk(4200);
    halt <= 1'b1;
    tk(20);
    halt <= 1'b0;
    svc(8'h19, 1000);
    rise(8);
    hold;
  endtask
  initial begin
    tk(6);
    sys_rst <= 1'b0;
    t_cfg;
    t_window;
    t_fields;
    t_upper;
    t_clk;
    t_idle;
    t_halt;
    t_pend;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
